// >>> hw/pwm_timer_pkg.sv
// package for the 10-bit bidirectional pwm timer/counter
// assumes an apb slave with 32-bit data, one word per register
`default_nettype none

package pwm_timer_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] addr_control_a  = 8'h00;
    localparam logic [7:0] addr_control_c  = 8'h04;
    localparam logic [7:0] addr_control_d  = 8'h08;
    localparam logic [7:0] addr_counter    = 8'h0c;
    localparam logic [7:0] addr_compare_a  = 8'h10;
    localparam logic [7:0] addr_top        = 8'h14;
    localparam logic [7:0] addr_status     = 8'h18;
    localparam logic [7:0] addr_clock_ctrl = 8'h1c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int pos_com_a   = 6;   // control_a: compare output mode [7:6]
    localparam int pos_pwm_a   = 1;   // control_a: pwm enable channel a
    localparam int pos_wgm0    = 0;   // control_d: waveform mode bit
    localparam int pos_wgm1    = 1;   // control_d: waveform mode bit high
    localparam int pos_ovf     = 2;   // status: overflow flag
    localparam int pos_ovf_ie  = 0;   // status: overflow interrupt enable
    localparam int pos_pll_clock_enable    = 4;   // clock_ctrl: pll clock enable
    localparam int pos_dir     = 1;   // status: count direction (read only)
    localparam int pos_wave    = 3;   // status: waveform output a

    // ------------------------------------------------------------
    // values after reset and limits
    // ------------------------------------------------------------
    localparam logic [9:0] top_reset   = 10'h0ff;
    localparam logic [9:0] count_max   = 10'h3ff;
    localparam logic [9:0] count_zero  = 10'h000;
    localparam logic [3:0] cs_stopped  = 4'h0;
    localparam logic [3:0] prescale_divisor = 4'h1; // log2 step of each cs code

    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        mode_normal,
        mode_pfc_pwm,
        mode_single_six,
        mode_dual_six
    } wave_mode_t;

endpackage

`default_nettype wire

// >>> hw/pwm_timer.sv
// 10-bit bidirectional timer/counter with compare output pins, apb slave
// assumes apb inputs synchronous to clock; pll tick arrives synchronous too
//
// Operation
// - zero count raises bottom indication
// - maximum is 0x3ff
// - top compare register, resets to 0x0ff
// - each tick clears, increments or decrements
// - direction picks up/down; clear zeroes counter
// - top and bottom indications raised
// - tick from system clock or pll
// - clock select zero stops counting
// - cpu reads/writes counter anytime
// - cpu write beats clear or count
// - mode bits set counting sequence
// - overflow flag per mode, interrupt if enabled
// - pfc pwm modes 00 and 01
// - pfc pwm mode 10, true pin only
// - pfc pwm mode 11, true pin only
// - six-output mode drives all pairs from a
// - single-slope six, 01/10: clear match, set zero
// - single-slope six, 11: set match, clear zero
// - dual-slope six: up clear, down set; 11 inverts
// - counter write resumes upward counting
`default_nettype none

module pwm_timer (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pll_tick,
    output logic      [5:0]  compare_pin,
    output logic      [5:0]  compare_pin_oe,
    output logic             overflow_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  control_a;
        logic [7:0]  control_c;
        logic [7:0]  control_d;
        logic [3:0]  clock_select_field;
        logic        pll_clock_enable;
        logic        ovf_ie;
        logic [9:0]  counter_value;
        logic [9:0]  compare_a;
        logic [9:0]  top_compare_register;
        logic        count_down;
        logic        overflow_flag;
        logic        waveform_output_a;
        logic [15:0] prescale;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [5:0]  pin;
        logic [5:0]  pin_oe;
        logic        irq;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic        wr_acc;
    logic        rd_acc;
    logic        tick;
    logic        at_bottom;
    logic        at_top;
    logic        at_max;
    logic        match_a;
    logic [1:0]  com_a;
    logic        pwm_a;
    logic        six_out;
    logic        wgm0;
    pwm_timer_pkg::wave_mode_t mode;
    logic [15:0] prescale_mask;
    logic        mapped;
    logic        ovf_event;

    // ------------------------------------------------------------
    // decode and comparators
    // ------------------------------------------------------------
    // apb access phase: only its first cycle counts, so the master holding the
    // request until it sees pready cannot apply a write twice
    assign wr_acc = psel & penable & pwrite & ~st_reg.ready;
    assign rd_acc = psel & penable & ~pwrite & ~st_reg.ready;

    assign at_bottom = (st_reg.counter_value == pwm_timer_pkg::count_zero);
    assign at_max    = (st_reg.counter_value == pwm_timer_pkg::count_max);
    assign at_top    = (st_reg.counter_value == st_reg.top_compare_register);
    assign match_a   = (st_reg.counter_value == st_reg.compare_a);

    assign com_a   = st_reg.control_a[pwm_timer_pkg::pos_com_a +: 2];
    assign pwm_a   = st_reg.control_a[pwm_timer_pkg::pos_pwm_a];
    assign wgm0    = st_reg.control_d[pwm_timer_pkg::pos_wgm0];
    assign six_out = st_reg.control_d[pwm_timer_pkg::pos_wgm1];

    assign mapped = (paddr == pwm_timer_pkg::addr_control_a)
                  | (paddr == pwm_timer_pkg::addr_control_c)
                  | (paddr == pwm_timer_pkg::addr_control_d)
                  | (paddr == pwm_timer_pkg::addr_counter)
                  | (paddr == pwm_timer_pkg::addr_compare_a)
                  | (paddr == pwm_timer_pkg::addr_top)
                  | (paddr == pwm_timer_pkg::addr_status)
                  | (paddr == pwm_timer_pkg::addr_clock_ctrl);

    // mode decode from pwm enable and waveform mode bits
    always_comb begin
        if (!pwm_a) begin
            mode = pwm_timer_pkg::mode_normal;
        end else if (six_out) begin
            mode = wgm0 ? pwm_timer_pkg::mode_dual_six : pwm_timer_pkg::mode_single_six;
        end else begin
            mode = wgm0 ? pwm_timer_pkg::mode_pfc_pwm : pwm_timer_pkg::mode_single_six;
        end
    end

    // prescaler: cs code n counts every 2^(n-1) system clocks, or every 2^(n-1) pll ticks when the pll is enabled
    always_comb begin
        prescale_mask = 16'h0000;
        if (st_reg.clock_select_field > 4'h1) begin
            prescale_mask = 16'hffff >> (5'd17 - {1'b0, st_reg.clock_select_field});
        end
    end

    // the pll tick is taken only when its enable is set; a slow path clock
    // would otherwise need a second domain, which this block avoids
    assign tick = (st_reg.clock_select_field != pwm_timer_pkg::cs_stopped)
                & (st_reg.pll_clock_enable ? pll_tick : 1'b1)
                & ((st_reg.prescale & prescale_mask) == 16'h0000);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.ready = 1'b0;
        st_next.err   = 1'b0;
        st_next.rdata = 32'h0000_0000;
        ovf_event     = 1'b0;

        if (st_reg.clock_select_field != pwm_timer_pkg::cs_stopped &&
            (!st_reg.pll_clock_enable || pll_tick)) begin
            st_next.prescale = st_reg.prescale + 16'h0001;
        end

        // counting sequence per mode
        if (tick) begin
            unique case (mode)
                pwm_timer_pkg::mode_pfc_pwm,
                pwm_timer_pkg::mode_dual_six: begin
                    // dual slope: turn at top and at bottom
                    if (!st_reg.count_down && at_top) begin
                        st_next.count_down    = 1'b1;
                        st_next.counter_value = st_reg.counter_value - 10'h001;
                    end else if (st_reg.count_down && at_bottom) begin
                        st_next.count_down    = 1'b0;
                        st_next.counter_value = st_reg.counter_value + 10'h001;
                        st_next.overflow_flag = 1'b1;
                        ovf_event             = 1'b1;
                    end else if (st_reg.count_down) begin
                        st_next.counter_value = st_reg.counter_value - 10'h001;
                    end else begin
                        st_next.counter_value = st_reg.counter_value + 10'h001;
                    end
                end
                default: begin
                    // single slope: clear after top
                    st_next.count_down = 1'b0;
                    if (at_top || at_max) begin
                        st_next.counter_value = pwm_timer_pkg::count_zero;
                        st_next.overflow_flag = 1'b1;
                        ovf_event             = 1'b1;
                    end else begin
                        st_next.counter_value = st_reg.counter_value + 10'h001;
                    end
                end
            endcase

            // waveform generator on channel a
            unique case (mode)
                pwm_timer_pkg::mode_pfc_pwm,
                pwm_timer_pkg::mode_dual_six: begin
                    if (match_a && com_a != 2'b00) begin
                        // 01/10: clear on up, set on down; 11 inverted
                        st_next.waveform_output_a = (com_a == 2'b11) ^ st_reg.count_down;
                    end
                end
                pwm_timer_pkg::mode_single_six: begin
                    if (match_a && com_a != 2'b00) begin
                        st_next.waveform_output_a = (com_a == 2'b11);
                    end else if (at_bottom && com_a != 2'b00) begin
                        st_next.waveform_output_a = (com_a != 2'b11);
                    end
                end
                default: begin
                    if (match_a && com_a == 2'b01) begin
                        st_next.waveform_output_a = ~st_reg.waveform_output_a;
                    end else if (match_a && com_a[1]) begin
                        st_next.waveform_output_a = com_a[0];
                    end
                end
            endcase
        end

        // apb writes; a counter write overrides the count above
        if (wr_acc) begin
            unique case (paddr)
                pwm_timer_pkg::addr_control_a:  st_next.control_a = pwdata[7:0];
                pwm_timer_pkg::addr_control_c:  st_next.control_c = pwdata[7:0];
                pwm_timer_pkg::addr_control_d:  st_next.control_d = pwdata[7:0];
                pwm_timer_pkg::addr_counter: begin
                    st_next.counter_value = pwdata[9:0];
                    st_next.count_down    = 1'b0;
                end
                pwm_timer_pkg::addr_compare_a:  st_next.compare_a = pwdata[9:0];
                pwm_timer_pkg::addr_top:        st_next.top_compare_register = pwdata[9:0];
                pwm_timer_pkg::addr_status: begin
                    st_next.ovf_ie = pwdata[pwm_timer_pkg::pos_ovf_ie];
                    // write one clears; a same-cycle overflow still sets
                    if (pwdata[pwm_timer_pkg::pos_ovf] && !ovf_event) begin
                        st_next.overflow_flag = 1'b0;
                    end
                end
                pwm_timer_pkg::addr_clock_ctrl: begin
                    st_next.clock_select_field = pwdata[3:0];
                    st_next.pll_clock_enable   = pwdata[pwm_timer_pkg::pos_pll_clock_enable];
                end
                default: ;
            endcase
        end

        // apb read data and answer
        if (psel && penable && !st_reg.ready) begin
            st_next.ready = 1'b1;
            st_next.err   = ~mapped;
        end
        if (rd_acc) begin
            unique case (paddr)
                pwm_timer_pkg::addr_control_a:  st_next.rdata = {24'h000000, st_reg.control_a};
                pwm_timer_pkg::addr_control_c:  st_next.rdata = {24'h000000, st_reg.control_c};
                pwm_timer_pkg::addr_control_d:  st_next.rdata = {24'h000000, st_reg.control_d};
                pwm_timer_pkg::addr_counter:    st_next.rdata = {22'h0, st_reg.counter_value};
                pwm_timer_pkg::addr_compare_a:  st_next.rdata = {22'h0, st_reg.compare_a};
                pwm_timer_pkg::addr_top:        st_next.rdata = {22'h0,
                                                                 st_reg.top_compare_register};
                pwm_timer_pkg::addr_status:     st_next.rdata = {28'h0000000,
                    st_reg.waveform_output_a, st_reg.overflow_flag,
                    st_reg.count_down, st_reg.ovf_ie};
                pwm_timer_pkg::addr_clock_ctrl: st_next.rdata = {27'h0,
                    st_reg.pll_clock_enable, st_reg.clock_select_field};
                default:                        st_next.rdata = 32'h0000_0000;
            endcase
        end

        // pins: six-output mode fans channel a to all pairs
        st_next.irq = st_next.overflow_flag & st_next.ovf_ie;
        if (st_next.control_a[pwm_timer_pkg::pos_com_a +: 2] == 2'b00) begin
            st_next.pin_oe = 6'h00;
            st_next.pin    = 6'h00;
        end else if (st_next.control_d[pwm_timer_pkg::pos_wgm1]) begin
            st_next.pin    = {3{~st_next.waveform_output_a, st_next.waveform_output_a}};
            st_next.pin_oe = 6'h3f;
        end else begin
            st_next.pin    = {4'h0, ~st_next.waveform_output_a, st_next.waveform_output_a};
            // complement only in mode 01
            st_next.pin_oe = {4'h0,
                st_next.control_a[pwm_timer_pkg::pos_com_a +: 2] == 2'b01, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg                      <= '0;
            st_reg.top_compare_register <= pwm_timer_pkg::top_reset;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata         = st_reg.rdata;
    assign pready         = st_reg.ready;
    assign pslverr        = st_reg.err;
    assign compare_pin    = st_reg.pin;
    assign compare_pin_oe = st_reg.pin_oe;
    assign overflow_irq   = st_reg.irq;

endmodule

`default_nettype wire

// >>> sim/pwm_timer_props.sv
// checker for the pwm timer: apb handshake and compare pin relations
// assumes it sees only the ports of pwm_timer, attached by bind
`default_nettype none

module pwm_timer_props (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [5:0]  compare_pin,
    input wire logic [5:0]  compare_pin_oe
);
    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // first access cycle, before the answer
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_bad; s_access ##0 (paddr > 8'h1c || paddr[1:0] != 2'b00); endsequence
    sequence s_good; s_access ##0 (paddr <= 8'h1c && paddr[1:0] == 2'b00); endsequence
    property p_ack_wait; s_access |=> pready; endproperty
    property p_ack_pulse; pready |=> !pready; endproperty
    property p_ack_inside; pready |-> psel && penable; endproperty
    property p_err_bad; s_bad |=> pslverr; endproperty
    property p_ok_good; s_good |=> !pslverr; endproperty
    property p_err_ack; pslverr |-> pready; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_rdata_narrow; pready |-> prdata[31:10] == 22'h0; endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("no answer after access");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ready too long");
    a_ack_inside: assert property (p_ack_inside) else $error("ready outside access");
    a_err_bad: assert property (p_err_bad) else $error("unmapped not refused");
    a_ok_good: assert property (p_ok_good) else $error("mapped refused");
    a_err_ack: assert property (p_err_ack) else $error("error without ready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    a_rdata_narrow: assert property (p_rdata_narrow) else $error("wide read data");
    // ------------------------------------------------------------
    // compare pins
    // ------------------------------------------------------------
    // every pair copies channel a once the extra pairs are driven
    property p_pin_pairs;
        compare_pin_oe[2] |-> compare_pin[3:2] == compare_pin[1:0]
            && compare_pin[5:4] == compare_pin[1:0];
    endproperty
    property p_pair_compl; compare_pin_oe[1] |-> compare_pin[1] != compare_pin[0]; endproperty
    property p_true_first; compare_pin_oe[1] |-> compare_pin_oe[0]; endproperty
    a_pin_pairs: assert property (p_pin_pairs) else $error("pairs differ");
    a_pair_compl: assert property (p_pair_compl) else $error("not complement");
    a_true_first: assert property (p_true_first) else $error("complement alone");
endmodule

bind pwm_timer pwm_timer_props props (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_pin(compare_pin), .compare_pin_oe(compare_pin_oe));

`default_nettype wire

// >>> sim/cpu_bus_model.sv
// apb master standing in for the cpu on the register bus
// assumes the slave answers with pready; waits are bounded
`default_nettype none

module cpu_bus_model (
    input  wire logic        clock,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // ------------------------------------------------------------
    // one transfer, request held until ready is sampled
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic hung);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        hung = (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // released lines show no stale value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the pwm timer
// assumes cpu_bus_model as bus master and the bound checker
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, resetn, psel, penable, pwrite, pready, pslverr, pll_tick, irq, err, hung;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [5:0]  pin, oe;
    int          failures = 0;
    int          total_checks = 0;
    pwm_timer dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pll_tick(pll_tick), .compare_pin(pin), .compare_pin_oe(oe),
        .overflow_irq(irq));
    cpu_bus_model cpu (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // pll stand-in ticks every other clock
    always @(posedge clock) pll_tick <= ~pll_tick;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic in_range(input logic [31:0] got, input int lo, input int hi);
        check((got >= lo && got <= hi) ? got : 32'hffff_ffff, got);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cpu.xfer(w, a, d, q, err, hung);
        if (hung) begin
            failures++;
            give_verdict();
        end
    endtask
    // stop, load counter, run n clocks on a clock setting; the counter is left running
    task automatic run(input logic [31:0] start, input logic [31:0] clk, input int n);
        bus(1, pwm_timer_pkg::addr_clock_ctrl, 32'h0);
        bus(1, pwm_timer_pkg::addr_counter, start);
        bus(1, pwm_timer_pkg::addr_clock_ctrl, clk);
        repeat (n) @(posedge clock);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        bus(0, pwm_timer_pkg::addr_top, 0);
        check(q, 32'h0ff);
        bus(0, pwm_timer_pkg::addr_counter, 0);
        check(q, 32'h0);
        bus(0, 8'h40, 0);
        check({q[30:0], err}, 32'h1);
    endtask
    task automatic t_count();
        run(32'h3ff, 32'h0, 20);
        bus(0, pwm_timer_pkg::addr_counter, 0);
        check(q, 32'h3ff);
        bus(0, pwm_timer_pkg::addr_status, 0);
        check(q[1], 1'b0);
        run(32'h0, 32'h1, 40);
        bus(1, pwm_timer_pkg::addr_clock_ctrl, 32'h0);
        bus(0, pwm_timer_pkg::addr_counter, 0);
        in_range(q, 40, 48);
        run(32'h0, 32'h11, 40);
        bus(1, pwm_timer_pkg::addr_counter, 32'h100);
        bus(1, pwm_timer_pkg::addr_clock_ctrl, 32'h0);
        bus(0, pwm_timer_pkg::addr_counter, 0);
        in_range(q, 32'h100, 32'h104);
    endtask
    task automatic t_overflow();
        int n;
        bus(1, pwm_timer_pkg::addr_top, 32'h10);
        bus(1, pwm_timer_pkg::addr_control_a, 32'h42);
        bus(1, pwm_timer_pkg::addr_control_d, 32'h1);
        bus(1, pwm_timer_pkg::addr_status, 32'h5);
        run(32'h0, 32'h1, 0);
        n = 0;
        do begin
            bus(0, pwm_timer_pkg::addr_status, 0);
            n++;
        end while (q[1] !== 1'b1 && n < 40);
        check(q[1], 1'b1);
        repeat (60) @(posedge clock);
        bus(1, pwm_timer_pkg::addr_clock_ctrl, 32'h0);
        bus(0, pwm_timer_pkg::addr_status, 0);
        check({q[2], irq}, 2'b11);
        bus(1, pwm_timer_pkg::addr_status, 32'h4);
        bus(0, pwm_timer_pkg::addr_status, 0);
        check({q[2], irq}, 2'b00);
    endtask
    task automatic t_connect();
        logic [5:0] exp[4] = '{6'h00, 6'h03, 6'h01, 6'h01};
        for (int c = 0; c < 4; c++) begin
            bus(1, pwm_timer_pkg::addr_control_a, 32'(c * 64 + 2));
            check(oe, exp[c]);
        end
        bus(1, pwm_timer_pkg::addr_control_d, 32'h2);
        bus(1, pwm_timer_pkg::addr_control_a, 32'h42);
        check(oe, 6'h3f);
    endtask
    // high cycles of the channel a true pin over 128 clocks
    task automatic duty(input logic [31:0] ca, input logic [31:0] cd, input int lo, input int hi);
        int h;
        h = 0;
        bus(1, pwm_timer_pkg::addr_top, 32'h1f);
        bus(1, pwm_timer_pkg::addr_compare_a, 32'h8);
        bus(1, pwm_timer_pkg::addr_control_a, ca);
        bus(1, pwm_timer_pkg::addr_control_d, cd);
        run(32'h0, 32'h1, 64);
        repeat (128) begin
            @(posedge clock);
            h += (pin[0] === 1'b1);
        end
        in_range(h, lo, hi);
    endtask
    initial begin
        resetn = 1'b0;
        pll_tick = 1'b0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_count();
        t_overflow();
        t_connect();
        duty(32'h42, 32'h2, 28, 44);
        duty(32'h82, 32'h2, 28, 44);
        duty(32'hc2, 32'h2, 84, 100);
        duty(32'h82, 32'h1, 22, 40);
        duty(32'hc2, 32'h1, 88, 106);
        duty(32'h42, 32'h3, 22, 40);
        duty(32'hc2, 32'h3, 88, 106);
        give_verdict();
    end
endmodule

`default_nettype wire
